// >>> src/afe_seq_pkg.sv
// Shared constants and carriers for the front-end sample sequencer.
// Assumes a single 200 MHz clock domain; the time base is an enable pulse.
package afe_seq_pkg;

	// ============================================================
	// Clock and timing
	localparam int REF_CLK_HZ       = 200_000_000;
	localparam int TIME_BASE_MHZ_X1000 = 32_768; // Time base in Hz
	localparam int TIME_BASE_DIV    = REF_CLK_HZ / TIME_BASE_MHZ_X1000;
	localparam int CE_CLK_MULT      = 150;
	localparam int CONV_PERIODS     = 2;

	// ============================================================
	// Data widths and memory
	localparam int SAMPLE_W         = 22;
	localparam int MOD_SUM_W        = 16;
	localparam int MEM_WORDS        = 128;
	localparam int MEM_W            = 32;
	localparam int MEM_AW           = 7;
	localparam int MPU_W            = 8;

	// ============================================================
	// Fixed sample slots in the data memory
	localparam logic [6:0] SLOT_FIRST   = 7'h00;
	localparam logic [6:0] SLOT_SECOND  = 7'h01;
	localparam logic [6:0] SLOT_THIRD   = 7'h02;
	localparam logic [6:0] SLOT_FOURTH  = 7'h03;
	localparam logic [6:0] SLOT_TEMP    = 7'h04;
	localparam logic [6:0] SLOT_SUPPLY  = 7'h05;

	// ============================================================
	// Multiplexer input selections
	typedef enum logic [2:0] {
		SEL_SENSE_FIRST  = 3'b000,
		SEL_SENSE_SECOND = 3'b001,
		SEL_SENSE_THIRD  = 3'b010,
		SEL_SENSE_FOURTH = 3'b011,
		SEL_TEMP         = 3'b100,
		SEL_SUPPLY       = 3'b101
	} mux_sel_t;

	// Sequencer states
	typedef enum logic [1:0] {
		ST_IDLE    = 2'b00,
		ST_CONVERT = 2'b01,
		ST_STORE   = 2'b10
	} seq_state_t;

	// Sample write carried into the memory
	typedef struct packed {
		logic                  valid;
		logic [MEM_AW-1:0]     addr;
		logic [MEM_W-1:0]      data;
	} mem_wr_t;

endpackage : afe_seq_pkg

// >>> src/afe_decimator.sv
// Decimator that turns the modulator bit stream into one 22-bit result.
// Assumes start and done arrive from the sequencer on the same clock.
`timescale 1ns/1ps
module afe_decimator
	import afe_seq_pkg::*;
(
	// Clock and reset
	input  wire logic                clk,
	input  wire logic                srst,
	// Control
	input  wire logic                start,
	input  wire logic                finish,
	input  wire logic                mod_bit,
	// Result
	output logic [SAMPLE_W-1:0]      result,
	output logic                     result_valid
);

	logic [SAMPLE_W+3:0] acc;

	// ============================================================
	// Count ones over the conversion; simple sinc1, enough headroom
	always_ff @(posedge clk) begin
		if (srst || start) begin
			acc <= '0;
		end else begin
			acc <= acc + {{(SAMPLE_W+3){1'b0}}, mod_bit};
		end
	end

	// One result per conversion, truncated to the target width
	always_ff @(posedge clk) begin
		if (srst) begin
			result       <= '0;
			result_valid <= 1'b0;
		end else begin
			result_valid <= finish;
			if (finish) begin
				result <= acc[SAMPLE_W-1:0];
			end
		end
	end

endmodule : afe_decimator

// >>> src/afe_mux_sample_sequencer.sv
// Input multiplexer sequencer with conversion start and sample storage.
// Assumes the compute engine pulses PASS_START once per program pass and
// the MPU requests alternate passes through a level on ALT_REQ.
`timescale 1ns/1ps

// Contract
// - Regular pass selects inputs one to four
// - Alternate pass: temp, second, supply, fourth
// - Mux logic runs on time base enable
// - Each compute pass restarts the sequence
// - One conversion triggered per mux state
// - Conversion lasts two time base periods; first of a pass lasts one to two, as divider is not restarted
// - Results are 22 bits wide
// - Decimator yields one result per conversion
// - Result stored at slot fixed by selection
// - Memory readable by engine and MPU
// - Engine fills displaced samples
// - Memory holds 128 words of 32 bits
// - MPU byte access through holding registers
// - Engine clock is 150 times time base
module afe_mux_sample_sequencer
	import afe_seq_pkg::*;
(
	// Clock and reset
	input  wire logic                REF_CLK,
	input  wire logic                SRST,
	// Compute engine side
	input  wire logic                PASS_START,
	input  wire logic                CE_RD,
	input  wire logic [MEM_AW-1:0]   CE_ADDR,
	output logic [MEM_W-1:0]         CE_RDATA,
	output logic                     CE_CLK_EN,
	output logic                     FILL_NEEDED,
	// MPU side
	input  wire logic                ALT_REQ,
	input  wire logic                MPU_RD,
	input  wire logic                MPU_WR,
	input  wire logic [MEM_AW-1:0]   MPU_ADDR,
	input  wire logic [1:0]          MPU_BYTE,
	input  wire logic [MPU_W-1:0]    MPU_WDATA,
	output logic [MPU_W-1:0]         MPU_RDATA,
	output logic                     MPU_WAIT,
	// Analog front end
	input  wire logic                MOD_BIT,
	output mux_sel_t                 MUX_SEL,
	output logic                     CONV_ACTIVE,
	output logic                     ALT_ACTIVE,
	output logic                     SAMPLE_WRITTEN
);

	logic [MEM_W-1:0]  mem [MEM_WORDS];
	logic [15:0]       tb_div;
	logic              tb_tick;
	logic [12:0]       ce_phase;
	seq_state_t        state;
	logic [1:0]        mux_state;
	logic [1:0]        period_cnt;
	logic              alt_latched;
	logic              conv_start;
	logic              conv_finish;
	logic [SAMPLE_W-1:0] dec_result;
	logic              dec_valid;
	mem_wr_t           wr;
	mem_wr_t           mpu_wr;
	logic [MEM_W-1:0]  hold_rd;
	logic [MEM_W-1:0]  hold_wr;
	logic              mpu_busy;
	logic [MEM_AW-1:0] sample_slot;

	// ============================================================
	// Time base divider; REF_CLK divided by TIME_BASE_DIV gives the 32.768 kHz enable
	always_ff @(posedge REF_CLK) begin
		if (SRST || tb_tick) begin
			tb_div <= '0;
		end else begin
			tb_div <= tb_div + 16'h0001;
		end
	end
	assign tb_tick = (tb_div == 16'(TIME_BASE_DIV - 1));

	// Engine clock enable from a phase accumulator: exactly 150 pulses per
	// time base period; the ratio is not whole, so gaps are 40 or 41 cycles
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			ce_phase <= '0;
		end else if (CE_CLK_EN) begin
			ce_phase <= ce_phase + 13'(CE_CLK_MULT) - 13'(TIME_BASE_DIV);
		end else begin
			ce_phase <= ce_phase + 13'(CE_CLK_MULT);
		end
	end
	assign CE_CLK_EN = (ce_phase >=
		13'(TIME_BASE_DIV - CE_CLK_MULT));

	// ============================================================
	// Pass sequencer; a new pass aborts any old one
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			state       <= ST_IDLE;
			mux_state   <= 2'b00;
			period_cnt  <= 2'b00;
			alt_latched <= 1'b0;
		end else if (PASS_START) begin
			state       <= ST_CONVERT;
			mux_state   <= 2'b00;
			period_cnt  <= 2'b00;
			alt_latched <= ALT_REQ;
		end else begin
			case (state)
				ST_IDLE: begin
					state <= ST_IDLE;
				end
				ST_CONVERT: begin
					if (tb_tick) begin
						if (period_cnt == 2'(CONV_PERIODS - 1)) begin
							period_cnt <= 2'b00;
							state      <= ST_STORE;
						end else begin
							period_cnt <= period_cnt + 2'b01;
						end
					end
				end
				ST_STORE: begin
					if (mux_state == 2'b11) begin
						state <= ST_IDLE;
					end else begin
						mux_state <= mux_state + 2'b01;
						state     <= ST_CONVERT;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	// Start pulses on entry to each conversion, finish on its last tick
	assign conv_start  = PASS_START ||
		(state == ST_STORE && mux_state != 2'b11);
	assign conv_finish = (state == ST_CONVERT) && tb_tick &&
		(period_cnt == 2'(CONV_PERIODS - 1));

	// ============================================================
	// Input selection per mux state
	always_comb begin
		MUX_SEL     = SEL_SENSE_FIRST;
		sample_slot = SLOT_FIRST;
		case (mux_state)
			2'b00: begin
				MUX_SEL     = alt_latched ? SEL_TEMP : SEL_SENSE_FIRST;
				sample_slot = alt_latched ? SLOT_TEMP : SLOT_FIRST;
			end
			2'b01: begin
				MUX_SEL     = SEL_SENSE_SECOND;
				sample_slot = SLOT_SECOND;
			end
			2'b10: begin
				MUX_SEL     = alt_latched ? SEL_SUPPLY : SEL_SENSE_THIRD;
				sample_slot = alt_latched ? SLOT_SUPPLY : SLOT_THIRD;
			end
			default: begin
				MUX_SEL     = SEL_SENSE_FOURTH;
				sample_slot = SLOT_FOURTH;
			end
		endcase
	end

	assign CONV_ACTIVE = (state == ST_CONVERT);
	assign ALT_ACTIVE  = alt_latched && (state != ST_IDLE);
	// Engine must fill the first and third slots after an alternate pass
	assign FILL_NEEDED = alt_latched;

	// ============================================================
	// Decimator instance
	afe_decimator u_dec (
		.clk          (REF_CLK),
		.srst         (SRST),
		.start        (conv_start),
		.finish       (conv_finish),
		.mod_bit      (MOD_BIT),
		.result       (dec_result),
		.result_valid (dec_valid)
	);

	// Sample write; mux state is still that of the finished conversion
	always_comb begin
		wr.valid = dec_valid;
		wr.addr  = sample_slot;
		wr.data  = {{(MEM_W-SAMPLE_W){dec_result[SAMPLE_W-1]}}, dec_result};
	end
	assign SAMPLE_WRITTEN = dec_valid;

	// ============================================================
	// MPU holding registers: bytes gather into a word, write on byte 3
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			hold_wr  <= '0;
			mpu_busy <= 1'b0;
		end else begin
			mpu_busy <= (MPU_RD || MPU_WR) && !mpu_busy;
			if (MPU_WR) begin
				hold_wr[8*MPU_BYTE +: 8] <= MPU_WDATA;
			end
		end
	end
	// One wait state per access while the word is fetched
	assign MPU_WAIT = (MPU_RD || MPU_WR) && !mpu_busy;

	always_comb begin
		mpu_wr.valid = MPU_WR && (MPU_BYTE == 2'b11) && !dec_valid;
		mpu_wr.addr  = MPU_ADDR;
		mpu_wr.data  = {MPU_WDATA, hold_wr[23:0]};
	end

	// ============================================================
	// Data memory; samples take priority over MPU stores
	always_ff @(posedge REF_CLK) begin
		if (wr.valid) begin
			mem[wr.addr] <= wr.data;
		end else if (mpu_wr.valid) begin
			mem[mpu_wr.addr] <= mpu_wr.data;
		end
	end

	// Read ports for engine and MPU
	always_ff @(posedge REF_CLK) begin
		if (SRST) begin
			CE_RDATA  <= '0;
			hold_rd   <= '0;
			MPU_RDATA <= '0;
		end else begin
			if (CE_RD) begin
				CE_RDATA <= mem[CE_ADDR];
			end
			if (MPU_RD && !mpu_busy && MPU_BYTE == 2'b00) begin
				hold_rd <= mem[MPU_ADDR];
			end
			if (MPU_RD && mpu_busy) begin
				MPU_RDATA <= (MPU_BYTE == 2'b00) ?
					mem[MPU_ADDR][7:0] : hold_rd[8*MPU_BYTE +: 8];
			end
		end
	end

endmodule : afe_mux_sample_sequencer

// >>> bench/afe_ce_model.sv
// Engine-side read model for the sample memory.
// Assumes bench requests on the sequencer clock.
`timescale 1ns/1ps
module afe_ce_model (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       srst,
	// Bench request
	input  wire logic       go,
	input  wire logic [6:0] slot,
	// Engine read port
	output logic            CE_RD,
	output logic [6:0]      CE_ADDR
);
	// ============================================================
	// One-cycle read; idle address scrambled so stale values show
	always_ff @(posedge clk) begin
		CE_RD   <= go && !srst;
		CE_ADDR <= srst ? 7'h00 : go ? slot : ~CE_ADDR;
	end
endmodule : afe_ce_model

// >>> bench/afe_seq_assertions.sv
// Checker for sequencer port timing.
// Assumes a bind onto the sequencer top.
`timescale 1ns/1ps
module afe_seq_assertions
	import afe_seq_pkg::*;
(
	// Clock and reset
	input wire logic     REF_CLK,
	input wire logic     SRST,
	// Requests
	input wire logic     PASS_START,
	input wire logic     ALT_REQ,
	input wire logic     MPU_RD,
	input wire logic     MPU_WR,
	// Outputs
	input wire logic     MPU_WAIT,
	input wire logic     CE_CLK_EN,
	input wire logic     FILL_NEEDED,
	input wire mux_sel_t MUX_SEL,
	input wire logic     CONV_ACTIVE,
	input wire logic     ALT_ACTIVE,
	input wire logic     SAMPLE_WRITTEN
);
	localparam int LO = TIME_BASE_DIV - 2;
	localparam int HI = 2 * TIME_BASE_DIV + 2;
	int len;
	default clocking cb @(posedge REF_CLK); endclocking
	default disable iff (SRST);
	// ============================================================
	// Conversion length; first one of a pass can be shorter
	always_ff @(posedge REF_CLK) begin
		len <= (SRST || !CONV_ACTIVE || PASS_START) ? 0 : len + 1;
	end
	sequence s_st(logic k, mux_sel_t s);
		SAMPLE_WRITTEN && ALT_ACTIVE == k && MUX_SEL == s && !PASS_START;
	endsequence
	property p_step(logic k, mux_sel_t a, mux_sel_t b);
		s_st(k, a) |-> ##[1:2] (CONV_ACTIVE && MUX_SEL == b);
	endproperty
	a_reg_one_two: assert property (
		p_step(0, SEL_SENSE_FIRST, SEL_SENSE_SECOND))
		else $error("order 0-1");
	a_reg_two_three: assert property (
		p_step(0, SEL_SENSE_SECOND, SEL_SENSE_THIRD))
		else $error("order 1-2");
	a_reg_three_four: assert property (
		p_step(0, SEL_SENSE_THIRD, SEL_SENSE_FOURTH))
		else $error("order 2-3");
	a_sub_temp_two: assert property (
		p_step(1, SEL_TEMP, SEL_SENSE_SECOND))
		else $error("sub 0-1");
	a_sub_two_supply: assert property (
		p_step(1, SEL_SENSE_SECOND, SEL_SUPPLY))
		else $error("sub 1-2");
	a_sub_supply_four: assert property (
		p_step(1, SEL_SUPPLY, SEL_SENSE_FOURTH))
		else $error("sub 2-3");
	a_pass_restart: assert property (
		PASS_START |=> CONV_ACTIVE && ALT_ACTIVE == $past(ALT_REQ) &&
		MUX_SEL == ($past(ALT_REQ) ? SEL_TEMP : SEL_SENSE_FIRST))
		else $error("restart");
	a_store_after: assert property (
		$fell(CONV_ACTIVE) && !$past(PASS_START) |-> SAMPLE_WRITTEN)
		else $error("no store");
	a_conv_len: assert property (
		$fell(CONV_ACTIVE) |-> len inside {[LO:HI]})
		else $error("length");
	// Engine enable gaps are 40 or 41 cycles
	a_ce_clk_gap: assert property (
		CE_CLK_EN |=> !CE_CLK_EN [*8] ##[32:33] CE_CLK_EN)
		else $error("engine tick");
	a_fill_flag: assert property (
		PASS_START |=> FILL_NEEDED == $past(ALT_REQ))
		else $error("fill");
	a_fill_hold: assert property (
		!PASS_START |=> $stable(FILL_NEEDED))
		else $error("fill hold");
	a_mpu_wait: assert property (
		$rose(MPU_RD) |-> MPU_WAIT ##1 !MPU_WAIT)
		else $error("wait");
	a_mpu_wr_wait: assert property (
		$rose(MPU_WR) |-> MPU_WAIT ##1 !MPU_WAIT)
		else $error("write wait");
endmodule : afe_seq_assertions
bind afe_mux_sample_sequencer afe_seq_assertions chk_u (.REF_CLK,
	.SRST, .PASS_START, .ALT_REQ, .MPU_RD, .MPU_WR, .MPU_WAIT, .CE_CLK_EN,
	.FILL_NEEDED, .MUX_SEL, .CONV_ACTIVE, .ALT_ACTIVE, .SAMPLE_WRITTEN);

// >>> bench/testbench.sv
// Self-checking bench for the sample sequencer.
// Assumes the read model and checker compile first.
`timescale 1ns/1ps
module testbench;
	import afe_seq_pkg::*;
	logic        REF_CLK = 0, SRST = 1, PASS_START = 0, ALT_REQ = 0;
	logic        MPU_RD = 0, MPU_WR = 0, MOD_BIT = 0, ce_go = 0;
	logic [1:0]  MPU_BYTE = 2'h0;
	logic [6:0]  MPU_ADDR = 7'h00, CE_ADDR, ce_slot = 7'h00;
	logic [7:0]  MPU_WDATA = 8'h00, MPU_RDATA;
	logic [31:0] CE_RDATA, rnd_word;
	logic        CE_RD, CE_CLK_EN, FILL_NEEDED, MPU_WAIT;
	logic        CONV_ACTIVE, ALT_ACTIVE, SAMPLE_WRITTEN;
	mux_sel_t    MUX_SEL, cur, exp_q[$];
	int          bad_count = 0, samples_checked = 0, cycles = 0;
	// Input order: regular row, then substituted row
	mux_sel_t    tbl[2][4] = '{'{SEL_SENSE_FIRST, SEL_SENSE_SECOND,
		SEL_SENSE_THIRD, SEL_SENSE_FOURTH}, '{SEL_TEMP,
		SEL_SENSE_SECOND, SEL_SUPPLY, SEL_SENSE_FOURTH}};
	afe_mux_sample_sequencer dut_u (.REF_CLK(REF_CLK), .SRST(SRST),
		.PASS_START(PASS_START), .CE_RD(CE_RD), .CE_ADDR(CE_ADDR),
		.CE_RDATA(CE_RDATA), .CE_CLK_EN(CE_CLK_EN),
		.FILL_NEEDED(FILL_NEEDED), .ALT_REQ(ALT_REQ), .MPU_RD(MPU_RD),
		.MPU_WR(MPU_WR), .MPU_ADDR(MPU_ADDR), .MPU_BYTE(MPU_BYTE),
		.MPU_WDATA(MPU_WDATA), .MPU_RDATA(MPU_RDATA), .MPU_WAIT(MPU_WAIT),
		.MOD_BIT(MOD_BIT), .MUX_SEL(MUX_SEL), .CONV_ACTIVE(CONV_ACTIVE),
		.ALT_ACTIVE(ALT_ACTIVE), .SAMPLE_WRITTEN(SAMPLE_WRITTEN));
	afe_ce_model ce_u (.clk(REF_CLK), .srst(SRST), .go(ce_go),
		.slot(ce_slot), .CE_RD(CE_RD), .CE_ADDR(CE_ADDR));
	// ============================================================
	// Clock, modulator noise and hang guard
	initial forever #2.5 REF_CLK = ~REF_CLK;
	// All random draws live in this one process, seeded once at its start
	always @(posedge REF_CLK) begin
		if (cycles == 0) void'($urandom(55903));
		MOD_BIT  <= 1'($urandom);
		rnd_word <= $urandom;
		cycles++;
		if (cycles == 95000) begin
			bad_count++;
			print_verdict();
		end
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		samples_checked++;
		if (seen !== want) begin
			bad_count++;
			$display("mismatch t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask : check
	// Watcher: selection held in conversion meets oldest note
	always @(negedge REF_CLK) begin
		if (CONV_ACTIVE === 1'b1) cur = MUX_SEL;
		if (SAMPLE_WRITTEN === 1'b1)
			check(32'(cur), 32'(exp_q.pop_front()));
	end
	task ce_read(input logic [6:0] a, output logic [31:0] d);
		@(posedge REF_CLK);
		ce_go <= 1'b1;
		ce_slot <= a;
		@(posedge REF_CLK);
		ce_go <= 1'b0;
		repeat (2) @(negedge REF_CLK);
		d = CE_RDATA;
	endtask : ce_read
	// Held until wait is seen low, then released with address scrambled
	task mpu_read(input logic [6:0] a, input logic [1:0] b,
		output logic [7:0] r);
		@(posedge REF_CLK);
		MPU_ADDR <= a;
		MPU_BYTE <= b;
		MPU_RD <= 1'b1;
		do @(negedge REF_CLK); while (MPU_WAIT !== 1'b0);
		@(posedge REF_CLK);
		MPU_RD <= 1'b0;
		MPU_ADDR <= ~MPU_ADDR;
		@(negedge REF_CLK);
		r = MPU_RDATA;
	endtask : mpu_read
	// Four byte strobes, each held until wait is seen low; byte 3 stores
	task mpu_write(input logic [6:0] a, input logic [31:0] w);
		for (int b = 0; b < 4; b++) begin
			@(posedge REF_CLK);
			MPU_ADDR  <= a;
			MPU_BYTE  <= 2'(b);
			MPU_WDATA <= w[8*b +: 8];
			MPU_WR    <= 1'b1;
			do @(negedge REF_CLK); while (MPU_WAIT !== 1'b0);
			@(posedge REF_CLK);
			MPU_WR <= 1'b0;
		end
	endtask : mpu_write
	// ============================================================
	// One pass; request flipped right after start to prove the latch
	task run_pass(input logic k, input int n);
		logic [31:0] d;
		logic [7:0]  r;
		for (int i = 0; i < n; i++) exp_q.push_back(tbl[k][i]);
		@(posedge REF_CLK);
		ALT_REQ <= k;
		PASS_START <= 1'b1;
		@(posedge REF_CLK);
		PASS_START <= 1'b0;
		ALT_REQ <= ~k;
		for (int i = 0; i < n; i++) begin
			do @(negedge REF_CLK); while (SAMPLE_WRITTEN !== 1'b1);
			check({ALT_ACTIVE, FILL_NEEDED}, {k, k});
			// Slot numbers equal the selection codes
			ce_read(7'(tbl[k][i]), d);
			check({d[31:22], d != 0}, 11'h001);
			if (tbl[k][i] == SEL_TEMP) begin
				mpu_read(SLOT_TEMP, 2'h0, r);
				check(r, d[7:0]);
				mpu_read(SLOT_TEMP, 2'h3, r);
				check(r, 8'h00);
			end
		end
	endtask : run_pass
	task print_verdict();
		$display("checked %0d bad %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : print_verdict
	initial begin
		logic [31:0] w;
		logic [31:0] d;
		logic [7:0]  r;
		repeat (4) @(posedge REF_CLK);
		SRST <= 1'b0;
		// Byte writes gather into one word; both ports read it back
		w = rnd_word;
		mpu_write(7'h10, w);
		ce_read(7'h10, d);
		check(d, w);
		mpu_read(7'h10, 2'h0, r);
		check(r, w[7:0]);
		mpu_read(7'h10, 2'h2, r);
		check(r, w[23:16]);
		run_pass(1'b0, 4);
		run_pass(1'b1, 3);
		// Restart during the last state of a substituted pass
		@(posedge REF_CLK);
		PASS_START <= 1'b1;
		@(posedge REF_CLK);
		PASS_START <= 1'b0;
		@(negedge REF_CLK);
		check({CONV_ACTIVE, ALT_ACTIVE, MUX_SEL},
			{2'b10, SEL_SENSE_FIRST});
		print_verdict();
	end
endmodule : testbench
